// ===== logic/pmtr_top.sv
// program memory, fetch, table read path and serial programming port
`include "pmtr_map.svh"

// Functional notes
// - after reset the program counter holds address zero, the reset vector.
// - the store holds 16-bit words, 2K to 8K deep, fetched by the counter.
// - a table address is the high pointer placed above the low pointer; last-page reads put all ones above it.
// - a table read writes the word's low byte to the named data location.
// - every table read puts the word's high byte in the table high latch.
// - plain table reads go to sector 0, extended ones to any sector.
// - software can both read and write the table high latch.
// - every table read takes exactly two instruction cycles.
// - programming moves words both ways on one data pin with its clock.
// - an instruction cycle is four phases; the counter steps at t1.
module pmtr_top
   import pmtr_pkg::*;
#(
   parameter int P_DEPTH = 8192
) (
   // clock and reset
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_rst,
   // instruction fetch
   input  wire logic                  i_pc_load,
   input  wire logic [15:0]           i_pc_load_addr,
   output logic [15:0]                o_pc,
   output logic [15:0]                o_instr,
   output logic [3:0]                 o_phase,
   // table pointer and latch access
   input  wire logic                  i_ptr_low_wr,
   input  wire logic                  i_ptr_high_wr,
   input  wire logic                  i_high_latch_wr,
   input  wire logic [7:0]            i_wdata,
   output logic [7:0]                 o_ptr_low,
   output logic [7:0]                 o_ptr_high,
   output logic [7:0]                 o_table_high_latch,
   // table read request and data memory write
   input  wire logic                  i_tread_req,
   input  wire pmtr_op_t              i_tread_op,
   input  wire logic [9:0]            i_tread_dest,
   output logic                       o_busy,
   output logic                       o_dm_wr,
   output logic [9:0]                 o_dm_addr,
   output logic [7:0]                 o_dm_wdata,
   // serial programming pins
   input  wire logic                  i_prog_mode,
   input  wire logic                  i_prog_serial_clock,
   input  wire logic                  i_prog_serial_data,
   output logic                       o_prog_serial_data,
   output logic                       o_prog_serial_data_oe_n
);

   localparam int AW = $clog2(P_DEPTH);

   // word store depth
   // only 2K, 4K and 8K word stores are served
   if (P_DEPTH != 2048 && P_DEPTH != 4096 && P_DEPTH != 8192) begin : g_chk
      $error("P_DEPTH must be 2048, 4096 or 8192");
   end

   logic [`PMTR_WORD_BITS-1:0] flash_mem [P_DEPTH];
   logic                       t1_start;
   pmtr_state_t                state_reg;
   logic [2:0]                 cnt_reg;
   pmtr_op_t                   op_reg;
   logic [9:0]                 dest_reg;
   logic [AW-1:0]              taddr_reg;
   logic [15:0]                word_reg;
   logic [AW-1:0]              fetch_addr;
   logic                       tread_go;
   logic                       pc_hold;
   logic                       dm_done;
   logic [15:0]                full_ptr;
   logic [AW-1:0]              last_page_addr;

   pmtr_phase u_phase (
      .i_ref_clk  (i_ref_clk),
      .i_rst      (i_rst),
      .o_phase    (o_phase),
      .o_t1_start (t1_start)
   );

   // requests are only taken at an instruction boundary
   assign tread_go = i_tread_req && t1_start && state_reg == pmtr_st_idle;
   // second cycle of a table read is a dummy: no new fetch
   assign pc_hold  = state_reg == pmtr_st_run && cnt_reg == `PMTR_TREAD_HOLD;
   assign dm_done  = state_reg == pmtr_st_run && cnt_reg == `PMTR_TREAD_LAST;
   assign fetch_addr = i_pc_load ? i_pc_load_addr[AW-1:0] : o_pc[AW-1:0];
   assign full_ptr = {o_ptr_high, o_ptr_low};
   assign last_page_addr = {{(AW-8){1'b1}}, o_ptr_low};

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pc    <= `PMTR_RESET_VECTOR;
         o_instr <= 16'h0000;
      end else if (t1_start && !pc_hold) begin
         o_instr <= flash_mem[fetch_addr];
         o_pc    <= 16'(fetch_addr + AW'(1));  // wraps inside the store
      end
   end

   // pointers change only by software; the read path never writes them
   // pointers left alone
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_ptr_low  <= 8'h00;
         o_ptr_high <= 8'h00;
      end else begin
         if (i_ptr_low_wr) begin
            o_ptr_low <= i_wdata;
         end
         if (i_ptr_high_wr) begin
            o_ptr_high <= i_wdata;
         end
      end
   end

   // table read sequencer: eight clocks from boundary to boundary
   // two instruction cycles
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= pmtr_st_idle;
         cnt_reg   <= 3'h0;
         o_busy    <= 1'b0;
      end else begin
         case (state_reg)
            pmtr_st_idle: begin
               cnt_reg <= 3'h0;
               if (tread_go) begin
                  state_reg <= pmtr_st_run;
                  o_busy    <= 1'b1;
               end
            end
            pmtr_st_run: begin
               cnt_reg <= cnt_reg + 3'h1;
               if (dm_done) begin
                  state_reg <= pmtr_st_idle;
                  o_busy    <= 1'b0;
               end
            end
            default: begin
               state_reg <= pmtr_st_idle;
               o_busy    <= 1'b0;
            end
         endcase
      end
   end

   // capture the request; the word is read once, in the first phase
   // address formed at accept
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         op_reg    <= table_read_op;
         dest_reg  <= 10'h000;
         taddr_reg <= '0;
         word_reg  <= 16'h0000;
      end else if (tread_go) begin
         op_reg   <= i_tread_op;
         dest_reg <= i_tread_dest;
         if (i_tread_op == table_read_last_page_op
             || i_tread_op == extended_table_read_last_page_op) begin
            taddr_reg <= last_page_addr;
         end else begin
            taddr_reg <= full_ptr[AW-1:0];
         end
      end else if (state_reg == pmtr_st_run && cnt_reg == 3'h0) begin
         word_reg <= flash_mem[taddr_reg];
      end
   end

   // low byte to data memory, sector forced to 0 for plain variants
   // low byte write
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_dm_wr    <= 1'b0;
         o_dm_addr  <= 10'h000;
         o_dm_wdata <= 8'h00;
      end else begin
         o_dm_wr <= dm_done;
         if (dm_done) begin
            o_dm_wdata <= word_reg[7:0];
            if (op_reg inside {table_read_op, table_read_last_page_op}) begin
               o_dm_addr <= {`PMTR_SECTOR0, dest_reg[7:0]};
            end else begin
               o_dm_addr <= dest_reg;
            end
         end
      end
   end

   // hardware load wins over a software write in the same cycle, since
   // the read is the later instruction; an isr must save this latch
   // high byte latch
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_table_high_latch <= 8'h00;
      end else if (dm_done) begin
         o_table_high_latch <= word_reg[15:8];
      end else if (i_high_latch_wr) begin
         o_table_high_latch <= i_wdata;
      end
   end

   // ---- serial programming port ----
   logic        ck_s1, ck_s2, ck_s3;
   logic        dat_s1, dat_s2;
   logic        mode_s1, mode_s2;
   logic        ck_rise, ck_fall;
   logic [5:0]  pcnt_reg;
   logic [29:0] pshift_reg;
   logic [29:0] pshift_next;
   logic        pread_reg;
   logic [12:0] paddr_reg;
   logic [15:0] pout_reg;
   logic        pdrive;

   // pins come from the programmer's domain: two flops first
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         {ck_s1, ck_s2, ck_s3} <= 3'h0;
         {dat_s1, dat_s2}      <= 2'h0;
         {mode_s1, mode_s2}    <= 2'h0;
      end else begin
         ck_s1   <= i_prog_serial_clock;
         ck_s2   <= ck_s1;
         ck_s3   <= ck_s2;
         dat_s1  <= i_prog_serial_data;
         dat_s2  <= dat_s1;
         mode_s1 <= i_prog_mode;
         mode_s2 <= mode_s1;
      end
   end

   assign ck_rise     = ck_s2 && !ck_s3;
   assign ck_fall     = !ck_s2 && ck_s3;
   assign pshift_next = {pshift_reg[28:0], dat_s2};
   assign pdrive      = mode_s2 && pread_reg
                        && pcnt_reg >= `PMTR_FRAME_DATA_BEG;

   // frame: command bit, 13 address bits, 16 data bits, msb first
   // serial frame
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         pcnt_reg   <= 6'h00;
         pshift_reg <= 30'h0;
         pread_reg  <= 1'b0;
         paddr_reg  <= 13'h0000;
      end else if (!mode_s2) begin
         pcnt_reg  <= 6'h00;
         pread_reg <= 1'b0;
      end else if (ck_rise) begin
         pshift_reg <= pshift_next;
         pcnt_reg   <= (pcnt_reg == `PMTR_FRAME_LAST) ? 6'h00
                                                      : pcnt_reg + 6'h01;
         if (pcnt_reg == `PMTR_FRAME_ADDR_END) begin
            paddr_reg <= pshift_next[12:0];
            pread_reg <= !pshift_next[13];
         end else if (pcnt_reg == `PMTR_FRAME_LAST) begin
            pread_reg <= 1'b0;
         end
      end
   end

   // write frames commit the last sixteen bits to the array
   always_ff @(posedge i_ref_clk) begin
      if (mode_s2 && ck_rise && !pread_reg
          && pcnt_reg == `PMTR_FRAME_LAST) begin
         flash_mem[paddr_reg[AW-1:0]] <= pshift_next[15:0];
      end
   end

   // read data changes on falling clock edges so the programmer samples
   // on rising ones; pin is released outside the data field
   // read back
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         pout_reg                <= 16'h0000;
         o_prog_serial_data      <= 1'b0;
         o_prog_serial_data_oe_n <= 1'b1;
      end else begin
         o_prog_serial_data_oe_n <= !pdrive;
         if (mode_s2 && ck_rise && pcnt_reg == `PMTR_FRAME_ADDR_END) begin
            pout_reg <= flash_mem[pshift_next[AW-1:0]];
         end else if (pdrive && ck_fall) begin
            o_prog_serial_data <= pout_reg[15];
            pout_reg           <= {pout_reg[14:0], 1'b0};
         end
      end
   end

   // ---- checks ----
   sequence tread_run_s;
      o_busy [*8] ##1 (o_dm_wr && !o_busy);
   endsequence

   pc_reset_vec_a: assert property (
      @(posedge i_ref_clk) $fell(i_rst) |-> o_pc == `PMTR_RESET_VECTOR)
      else $error("counter not at reset vector after reset");

   pc_step_t1_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      t1_start && !pc_hold && !i_pc_load
      |=> o_pc == 16'($past(o_pc[AW-1:0]) + AW'(1)))
      else $error("counter did not step at t1");

   tread_two_cyc_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst) tread_go |=> tread_run_s)
      else $error("table read not two instruction cycles");

   dummy_cycle_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      tread_go ##4 1'b1 |=> $stable(o_pc))
      else $error("fetch advanced during table read dummy cycle");

   ptr_concat_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      tread_go && i_tread_op inside {table_read_op, extended_table_read_op}
      |=> 16'(taddr_reg) == ($past({o_ptr_high, o_ptr_low})
                            & 16'(P_DEPTH - 1)))
      else $error("table address not high over low pointer");

   bytes_split_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      $rose(o_dm_wr) |-> o_table_high_latch == word_reg[15:8]
                         && o_dm_wdata == word_reg[7:0])
      else $error("table word bytes misrouted");

   sector_zero_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      o_dm_wr && op_reg inside {table_read_op, table_read_last_page_op}
      |-> o_dm_addr[9:8] == `PMTR_SECTOR0)
      else $error("plain table read left sector 0");

   ptr_stable_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      o_busy && !i_ptr_low_wr && !i_ptr_high_wr
      |=> $stable(o_ptr_low) && $stable(o_ptr_high))
      else $error("table read disturbed the pointers");

   latch_sw_write_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      i_high_latch_wr && !dm_done |=> o_table_high_latch == $past(i_wdata))
      else $error("software write to table high latch lost");

   prog_drive_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      !o_prog_serial_data_oe_n |-> $past(pread_reg)
         && $past(pcnt_reg) >= `PMTR_FRAME_DATA_BEG
         && $past(pcnt_reg) <= `PMTR_FRAME_LAST)
      else $error("data pin driven outside read field");

endmodule

// ===== logic/pmtr_map.svh
// constants for the program memory and table read block
`ifndef PMTR_MAP_SVH
`define PMTR_MAP_SVH

`define PMTR_RESET_VECTOR    16'h0000
`define PMTR_DEPTH_MIN       2048
`define PMTR_DEPTH_MAX       8192
`define PMTR_WORD_BITS       16
`define PMTR_PHASE_T1        4'h1
`define PMTR_PHASE_T2        4'h2
`define PMTR_PHASE_T3        4'h4
`define PMTR_PHASE_T4        4'h8
`define PMTR_TREAD_LAST      3'h7
`define PMTR_TREAD_HOLD      3'h3
`define PMTR_SECTOR0         2'h0
`define PMTR_FRAME_ADDR_END  6'h0d
`define PMTR_FRAME_DATA_BEG  6'h0e
`define PMTR_FRAME_LAST      6'h1d

`endif

// ===== logic/pmtr_pkg.sv
// types shared by the program memory and table read block
package pmtr_pkg;

   typedef enum logic [1:0] {
      table_read_op                    = 2'h0,
      table_read_last_page_op          = 2'h1,
      extended_table_read_op           = 2'h2,
      extended_table_read_last_page_op = 2'h3
   } pmtr_op_t;

   typedef enum logic [1:0] {
      pmtr_st_idle = 2'b01,
      pmtr_st_run  = 2'b10
   } pmtr_state_t;

endpackage

// ===== logic/pmtr_phase.sv
// four-phase instruction cycle generator
`include "pmtr_map.svh"

module pmtr_phase (
   // clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst,
   // phase outputs
   output logic [3:0]      o_phase,
   output logic            o_t1_start
);

   // reset parks in t4 so that the first edge after release opens a t1
   // four phase ring
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_phase <= `PMTR_PHASE_T4;
      end else begin
         o_phase <= {o_phase[2:0], o_phase[3]};
      end
   end

   // high in t4: the coming edge starts the next instruction cycle
   assign o_t1_start = o_phase[3];

   // phases never overlap and never vanish
   phase_onehot_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      $onehot(o_phase) && ($past(i_rst)
         || o_phase == {$past(o_phase[2:0]), $past(o_phase[3])}))
      else $error("phase ring lost its single active phase");

endmodule

// ===== bench/pmtr_cpu_model.sv
// cpu core stand-in that issues jumps and table reads at t4
module pmtr_cpu_model
   import pmtr_pkg::*;
(
   // clock and device status
   input  wire logic       i_ref_clk,
   input  wire logic [3:0] i_phase,
   input  wire logic       i_busy,
   // requests to the device
   output pmtr_op_t        o_tread_op,
   output logic            o_tread_req,
   output logic [9:0]      o_tread_dest,
   output logic            o_pc_load,
   output logic [15:0]     o_pc_load_addr
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle request lines at time zero
   initial begin
      o_tread_op     = table_read_op;
      o_tread_req    = 1'b0;
      o_tread_dest   = 10'h000;
      o_pc_load      = 1'b0;
      o_pc_load_addr = 16'h0000;
   end

   // wait for an idle t4; a gap models a slow core
   task automatic wait_slot(input int gap);
      int n;
      n = 0;
      while (n <= gap) begin
         @(posedge i_ref_clk);
         #1;
         if (i_phase == 4'h8 && !i_busy)
            n++;
      end
   endtask

   task automatic issue_read(input pmtr_op_t op, input logic [9:0] dest,
                             input int gap);
      wait_slot(gap);
      o_tread_req  = 1'b1;
      o_tread_op   = op;
      o_tread_dest = dest;
      @(posedge i_ref_clk);
      #1;
      o_tread_req  = 1'b0;
      o_tread_dest = ~dest;  // released lines must not keep old value
   endtask

   // jump: load address held across the t4 edge only
   task automatic jump(input logic [15:0] addr);
      wait_slot(0);
      o_pc_load      = 1'b1;
      o_pc_load_addr = addr;
      @(posedge i_ref_clk);
      #1;
      o_pc_load      = 1'b0;
      o_pc_load_addr = ~addr;
   endtask
endmodule

// ===== bench/tb.sv
// self-checking bench for the program memory and table read block
module tb
   import pmtr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int DEPTH = 2048;
   localparam logic [7:0] HI = 8'h01;
   localparam logic [7:0] LO = 8'h06;

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        lo_wr = 1'b0;
   logic        hi_wr = 1'b0;
   logic        lt_wr = 1'b0;
   logic [7:0]  wdata = 8'h00;
   logic        prog_mode = 1'b0;
   logic        sclk = 1'b0;
   logic        sd_drv = 1'b0;
   logic        o_sd;
   logic        oe_n;
   wire logic   sd;
   logic        pc_load;
   logic [15:0] pc_addr;
   logic [15:0] pc;
   logic [15:0] instr;
   logic [3:0]  phase;
   logic [7:0]  ptr_lo;
   logic [7:0]  ptr_hi;
   logic [7:0]  latch;
   logic        req;
   pmtr_op_t    op;
   logic [9:0]  dest;
   logic        busy;
   logic        dm_wr;
   logic [9:0]  dm_addr;
   logic [7:0]  dm_wdata;
   logic [15:0] img [int];
   int          n_mismatch = 0;
   int          checks = 0;

   // wire level: the device wins whenever it enables its driver
   assign sd = oe_n ? sd_drv : o_sd;

   // 250 MHz reference clock
   always #2 clk = ~clk;

   pmtr_top #(.P_DEPTH(DEPTH)) dut (
      .i_ref_clk(clk), .i_rst(rst), .i_pc_load(pc_load),
      .i_pc_load_addr(pc_addr), .o_pc(pc), .o_instr(instr),
      .o_phase(phase), .i_ptr_low_wr(lo_wr), .i_ptr_high_wr(hi_wr),
      .i_high_latch_wr(lt_wr), .i_wdata(wdata), .o_ptr_low(ptr_lo),
      .o_ptr_high(ptr_hi), .o_table_high_latch(latch),
      .i_tread_req(req), .i_tread_op(op), .i_tread_dest(dest),
      .o_busy(busy), .o_dm_wr(dm_wr), .o_dm_addr(dm_addr),
      .o_dm_wdata(dm_wdata), .i_prog_mode(prog_mode),
      .i_prog_serial_clock(sclk), .i_prog_serial_data(sd),
      .o_prog_serial_data(o_sd), .o_prog_serial_data_oe_n(oe_n));

   pmtr_cpu_model cpu (
      .i_ref_clk(clk), .i_phase(phase), .i_busy(busy),
      .o_tread_op(op), .o_tread_req(req), .o_tread_dest(dest),
      .o_pc_load(pc_load), .o_pc_load_addr(pc_addr));

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic step();
      @(posedge clk);
      #1;
   endtask

   // one serial bit; data is sampled late in the low half
   task automatic sbit(input logic b, output logic s);
      sd_drv = b;
      repeat (8) step();
      s = sd;
      sclk = 1'b1;
      repeat (8) step();
      sclk = 1'b0;
   endtask

   // whole frame: command, 13 address bits, 16 data bits, msb first
   task automatic frame(input logic wr, input logic [12:0] a,
                        input logic [15:0] d, output logic [15:0] q);
      logic        s;
      logic [29:0] v;
      v = {wr, a, d};
      prog_mode = 1'b1;
      for (int i = 29; i >= 0; i--) begin
         sbit(v[i], s);
         if (i < 16)
            q[i] = s;
      end
      prog_mode = 1'b0;
      repeat (8) step();
   endtask

   task automatic flash_wr(input logic [12:0] a, input logic [15:0] d);
      logic [15:0] q;
      frame(1'b1, a, d, q);
      img[a] = d;
      check(q, d);
   endtask

   // strobed write: 0 low pointer, 1 high pointer, 2 high latch
   task automatic wr8(input int sel, input logic [7:0] d);
      wdata = d;
      lo_wr = (sel == 0);
      hi_wr = (sel == 1);
      lt_wr = (sel == 2);
      step();
      lo_wr = 1'b0;
      hi_wr = 1'b0;
      lt_wr = 1'b0;
      // an idle edge keeps back to back calls from re-driving a strobe
      step();
   endtask

   // the reset branch first acts at the first edge, so look after it
   task automatic t_reset();
      step();
      check({12'h0, phase}, 16'h8);
      check(pc, 16'h0);
      check({14'h0, oe_n, busy}, 16'h2);
      step();
      rst = 1'b0;
      step();
      for (int i = 0; i < 8; i++) begin
         check({12'h0, phase}, 16'h1 << (i % 4));
         check(pc, 16'(1 + i / 4));
         step();
      end
   endtask

   // second reset mid-run restarts fetching at the vector
   task automatic t_rereset();
      rst = 1'b1;
      step();
      check(pc, 16'h0);
      rst = 1'b0;
      step();
      check(pc, 16'h1);
      check(instr, img[0]);
   endtask

   task automatic t_fetch();
      cpu.jump(16'h0106);
      check(instr, img[16'h0106]);
      check(pc, 16'h0107);
   endtask

   task automatic t_regs();
      wr8(0, LO);
      wr8(1, HI);
      wr8(2, 8'h7e);
      check({ptr_hi, ptr_lo}, {HI, LO});
      check({8'h0, latch}, 16'h007e);
   endtask

   // table read: busy span, byte split, sector, pointers kept
   task automatic t_tread(input pmtr_op_t o, input int gap);
      logic [1:0]  oc;
      logic [15:0] a;
      logic [15:0] w;
      oc = o;
      a = {HI, LO} & 16'(DEPTH - 1);
      if (oc[0])
         a = 16'(DEPTH - 256) | {8'h0, LO};
      w = img[a];
      cpu.issue_read(o, 10'h2a5, gap);
      repeat (8) begin
         check({15'h0, busy}, 16'h1);
         step();
      end
      check({14'h0, dm_wr, busy}, 16'h2);
      check({6'h0, dm_addr}, oc[1] ? 16'h02a5 : 16'h00a5);
      check({8'h0, dm_wdata}, {8'h0, w[7:0]});
      check({8'h0, latch}, {8'h0, w[15:8]});
      check({ptr_hi, ptr_lo}, {HI, LO});
      step();
      check({15'h0, dm_wr}, 16'h0);
   endtask

   task automatic give_verdict();
      if (n_mismatch == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // main sequence
   initial begin
      logic [15:0] q;
      t_reset();
      flash_wr(13'h0000, 16'h1234);
      flash_wr(13'h0106, 16'h5a3c);
      flash_wr(13'h0706, 16'hc3e1);
      frame(1'b0, 13'h0706, ~16'hc3e1, q);
      check(q, 16'hc3e1);
      check({15'h0, oe_n}, 16'h1);
      t_rereset();
      t_fetch();
      t_regs();
      for (int k = 0; k < 4; k++)
         t_tread(pmtr_op_t'(k), k);
      give_verdict();
   end

   // watchdog: the run needs about 2000 cycles
   initial begin
      #50000;
      n_mismatch++;
      give_verdict();
   end
endmodule
